/* src/phy_basic_map.vh */
`ifndef PHY_BASIC_MAP_VH
`define PHY_BASIC_MAP_VH
`define CTRL_ADDR 5'h00
`define STAT_ADDR 5'h01
`define CTRL_RST_BIT 15
`define CTRL_LOOP_BIT 14
`define CTRL_PWDN_BIT 11
`define CTRL_ISO_BIT 10
`define CTRL_FIXED 16'h2100
`define STAT_FIXED 16'h0061
`define STAT_RFLT_BIT 4
`define STAT_LINK_BIT 2
`define STAT_JAB_BIT 1
`define RST_CYCLES 8'h10
`define ZERO16 16'h0000
`endif

/* src/soft_reset_timer.v */
`timescale 1ns/100ps
`default_nettype none
`include "phy_basic_map.vh"
module soft_reset_timer #(
    parameter CW = 8
) (
    // Clock and control
    input wire clk_in,
    input wire rst_in,
    input wire en_in,
    // Request and status
    input wire start_in,
    output wire busy_out
);
    reg [CW-1:0] cnt_q;
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= {CW{1'b0}};
        end else if (en_in) begin
            if (start_in) begin
                cnt_q <= `RST_CYCLES;
            end else if (cnt_q != {CW{1'b0}}) begin
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
    assign busy_out = (cnt_q != {CW{1'b0}});
endmodule
`default_nettype wire

/* src/phy_basic_control_status.v */
`timescale 1ns/100ps
`default_nettype none
`include "phy_basic_map.vh"
// How it works
// - Writing one to control bit 15 starts coding-layer soft reset, self-clears when done.
// - Reset bit reads one while soft reset runs, zero otherwise.
// - Soft reset clears only standard coding-layer state, vendor settings kept.
// - Bit 14 loops MAC-side transmit data back onto receive lines.
// - No link-up indication while MAC-side loopback is on.
// - Bit 13 reads one, bit 12 reads zero, both read-only.
// - Bit 11 powers down PHY; register access still works.
// - Power-down is bit 11 OR low power-down pin; pin low sets bit.
// - Bit 10 isolates port from MAC-side interface; management still works.
// - Remote fault latches high, clears on status read or reset.
module phy_basic_control_status (
    // Clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // Register access
    input wire [4:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_wdata_in,
    output reg [15:0] reg_rdata_out,
    // Pins and events
    input wire irq_powerdown_pin_n_in,
    input wire remote_fault_in,
    input wire link_up_in,
    input wire jabber_in,
    // MAC-side interface
    input wire [3:0] mac_txd_in,
    input wire mac_txen_in,
    input wire [3:0] phy_rxd_in,
    input wire phy_rxdv_in,
    output reg [3:0] mac_rxd_out,
    output reg mac_rxdv_out,
    output reg [3:0] phy_txd_out,
    output reg phy_txen_out,
    // Status outputs
    output wire powerdown_out,
    output wire isolate_out,
    output wire loopback_out,
    output wire pcs_reset_out,
    output reg link_ind_out
);
    // Control bits
    reg loop_q;
    reg loop_d;
    reg pwdn_q;
    reg pwdn_d;
    reg iso_q;
    reg iso_d;
    // Latched status flags
    reg rflt_q;
    reg rflt_d;
    reg link_q;
    reg link_d;
    reg jab_q;
    reg jab_d;
    // Next read word and data path
    reg [15:0] rdata_d;
    reg [3:0] mac_rxd_d;
    reg mac_rxdv_d;
    reg [3:0] phy_txd_d;
    reg phy_txen_d;
    reg link_ind_d;
    // Decodes and conditions
    wire busy;
    wire pin_pwdn;
    wire wr_ctrl;
    wire rd_ctrl;
    wire rd_stat;
    wire rd_other;
    wire start;
    wire link_ok;
    wire quiet;

    // Register address match
    function addr_hit;
        input [4:0] addr;
        input [4:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Latch-high flag; the event wins over a read clear
    function latch_high;
        input cur;
        input evt;
        input clr;
        begin
            latch_high = evt || (cur && !clr);
        end
    endfunction

    // Control read word
    function [15:0] ctrl_word;
        input rst_b;
        input loop_b;
        input pwdn_b;
        input iso_b;
        begin
            ctrl_word = `CTRL_FIXED;
            ctrl_word[`CTRL_RST_BIT] = rst_b;
            ctrl_word[`CTRL_LOOP_BIT] = loop_b;
            ctrl_word[`CTRL_PWDN_BIT] = pwdn_b;
            ctrl_word[`CTRL_ISO_BIT] = iso_b;
        end
    endfunction

    // Status read word
    function [15:0] stat_word;
        input rflt_b;
        input link_b;
        input jab_b;
        begin
            stat_word = `STAT_FIXED;
            stat_word[`STAT_RFLT_BIT] = rflt_b;
            stat_word[`STAT_LINK_BIT] = link_b;
            stat_word[`STAT_JAB_BIT] = jab_b;
        end
    endfunction

    assign pin_pwdn = !irq_powerdown_pin_n_in;
    assign wr_ctrl = ce_in && reg_wr_in && addr_hit(reg_addr_in, `CTRL_ADDR);
    assign rd_ctrl = ce_in && reg_rd_in && addr_hit(reg_addr_in, `CTRL_ADDR);
    assign rd_stat = ce_in && reg_rd_in && addr_hit(reg_addr_in, `STAT_ADDR);
    assign rd_other = ce_in && reg_rd_in && !rd_ctrl && !rd_stat;
    assign start = wr_ctrl && reg_wdata_in[`CTRL_RST_BIT];
    assign link_ok = link_up_in && !loop_q && !powerdown_out;
    assign quiet = iso_q || powerdown_out || busy;

    soft_reset_timer #(.CW(8)) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .en_in(ce_in),
        .start_in(start),
        .busy_out(busy)
    );

    assign pcs_reset_out = busy;
    assign powerdown_out = pwdn_q || pin_pwdn;
    assign isolate_out = iso_q;
    assign loopback_out = loop_q;

    // Control bits next value
    always @* begin
        loop_d = loop_q;
        pwdn_d = pwdn_q;
        iso_d = iso_q;
        if (pin_pwdn) begin
            pwdn_d = 1'b1;
        end else if (wr_ctrl) begin
            pwdn_d = reg_wdata_in[`CTRL_PWDN_BIT];
        end
        if (wr_ctrl) begin
            loop_d = reg_wdata_in[`CTRL_LOOP_BIT];
            iso_d = reg_wdata_in[`CTRL_ISO_BIT];
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            loop_q <= 1'b0;
            pwdn_q <= 1'b0;
            iso_q <= 1'b0;
        end else if (ce_in) begin
            loop_q <= loop_d;
            pwdn_q <= pwdn_d;
            iso_q <= iso_d;
        end
    end

    // Latched status flags next value
    always @* begin
        rflt_d = latch_high(rflt_q, remote_fault_in, rd_stat);
        jab_d = latch_high(jab_q, jabber_in, rd_stat);
        link_d = link_q;
        if (!link_ok) begin
            link_d = 1'b0;
        end else if (rd_stat) begin
            link_d = 1'b1;
        end
    end

    // Soft reset clears the latched flags only
    always @(posedge clk_in) begin
        if (rst_in || (ce_in && busy)) begin
            rflt_q <= 1'b0;
            jab_q <= 1'b0;
            link_q <= 1'b0;
        end else if (ce_in) begin
            rflt_q <= rflt_d;
            jab_q <= jab_d;
            link_q <= link_d;
        end
    end

    // Read word next value; held between reads
    always @* begin
        rdata_d = reg_rdata_out;
        if (rd_ctrl) begin
            rdata_d = ctrl_word(busy || start, loop_q, powerdown_out, iso_q);
        end else if (rd_stat) begin
            rdata_d = stat_word(rflt_q || remote_fault_in, link_q && link_ok,
                jab_q || jabber_in);
        end else if (rd_other) begin
            rdata_d = `ZERO16;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= `ZERO16;
        end else if (ce_in) begin
            reg_rdata_out <= rdata_d;
        end
    end

    // Data path next value: isolate, power-down, loopback
    always @* begin
        link_ind_d = link_ok && !busy;
        mac_rxd_d = phy_rxd_in;
        mac_rxdv_d = phy_rxdv_in;
        phy_txd_d = mac_txd_in;
        phy_txen_d = mac_txen_in;
        if (quiet) begin
            mac_rxd_d = 4'h0;
            mac_rxdv_d = 1'b0;
            phy_txd_d = 4'h0;
            phy_txen_d = 1'b0;
        end else if (loop_q) begin
            mac_rxd_d = mac_txd_in;
            mac_rxdv_d = mac_txen_in;
            phy_txd_d = 4'h0;
            phy_txen_d = 1'b0;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            mac_rxd_out <= 4'h0;
            mac_rxdv_out <= 1'b0;
            phy_txd_out <= 4'h0;
            phy_txen_out <= 1'b0;
            link_ind_out <= 1'b0;
        end else if (ce_in) begin
            mac_rxd_out <= mac_rxd_d;
            mac_rxdv_out <= mac_rxdv_d;
            phy_txd_out <= phy_txd_d;
            phy_txen_out <= phy_txen_d;
            link_ind_out <= link_ind_d;
        end
    end
endmodule
`default_nettype wire

/* bench/mac_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_side_model(input wire logic clk_in, output logic [3:0] txd_out, output logic txen_out);
    // Transmit stream: rolling nibble
    initial begin
        txd_out = 4'h0;
        txen_out = 1'b1;
    end
    always @(negedge clk_in) txd_out <= txd_out + 4'h1;
endmodule
`default_nettype wire

/* bench/pbcs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module pbcs_monitor(input wire logic clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in, reg_rdata_out,
    input wire logic irq_powerdown_pin_n_in, powerdown_out, isolate_out, loopback_out,
    input wire logic pcs_reset_out, link_ind_out, mac_rxdv_out, phy_txen_out,
    input wire logic [3:0] mac_txd_in, mac_rxd_out, phy_txd_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence ctrl_wr;
        ce_in && reg_wr_in && reg_addr_in == 5'h00 && reg_wdata_in[15];
    endsequence
    sequence rst_hold;
        pcs_reset_out [*8] ##[1:12] !pcs_reset_out;
    endsequence
    soft_start_a: assert property (ctrl_wr |=> pcs_reset_out) else $error("start");
    soft_len_a: assert property ($rose(pcs_reset_out) |-> rst_hold) else $error("len");
    rd_fixed_a: assert property (ce_in && reg_rd_in && reg_addr_in == 5'h00 |=>
        reg_rdata_out[13:12] == 2'b10 && reg_rdata_out[9:0] == 10'h100) else $error("ro");
    pin_pwdn_a: assert property (!irq_powerdown_pin_n_in |-> powerdown_out) else $error("pin");
    loop_link_a: assert property (loopback_out |=> !link_ind_out) else $error("link");
    loop_data_a: assert property (loopback_out && !powerdown_out && !isolate_out && !pcs_reset_out
        |=> mac_rxd_out == $past(mac_txd_in)) else $error("loop");
    iso_path_a: assert property (isolate_out |=> !mac_rxdv_out && !phy_txen_out) else $error("iso");
    pwdn_path_a: assert property (powerdown_out |=> !phy_txen_out && !link_ind_out) else $error("pd");
    tx_pass_a: assert property (!loopback_out && !powerdown_out && !isolate_out && !pcs_reset_out
        |=> phy_txd_out == $past(mac_txd_in)) else $error("tx");
endmodule
bind phy_basic_control_status pbcs_monitor mon_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .irq_powerdown_pin_n_in(irq_powerdown_pin_n_in),
    .powerdown_out(powerdown_out),
    .isolate_out(isolate_out),
    .loopback_out(loopback_out),
    .pcs_reset_out(pcs_reset_out),
    .link_ind_out(link_ind_out),
    .mac_rxdv_out(mac_rxdv_out),
    .phy_txen_out(phy_txen_out),
    .mac_txd_in(mac_txd_in),
    .mac_rxd_out(mac_rxd_out),
    .phy_txd_out(phy_txd_out)
);
`default_nettype wire

/* bench/phy_basic_control_status_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_status_bench;
    logic clk_in = 0, rst_in = 1, wr = 0, rd = 0, pin_n = 1, rflt = 0, link = 0, txen, mrxdv, pwdn, lind;
    logic prxdv = 0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wd = 16'h0000, rdata;
    logic [3:0] txd;
    int fail_count = 0, n_compared = 0, cyc = 0;
    always #2 clk_in = ~clk_in;
    mac_side_model mac_u (.clk_in(clk_in), .txd_out(txd), .txen_out(txen));
    phy_basic_control_status dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
        .reg_rdata_out(rdata), .irq_powerdown_pin_n_in(pin_n), .remote_fault_in(rflt),
        .link_up_in(link), .jabber_in(1'b0), .mac_txd_in(txd), .mac_txen_in(txen),
        .phy_rxd_in(4'h5), .phy_rxdv_in(prxdv), .mac_rxd_out(), .mac_rxdv_out(mrxdv),
        .phy_txd_out(), .phy_txen_out(), .powerdown_out(pwdn), .isolate_out(),
        .loopback_out(), .pcs_reset_out(), .link_ind_out(lind));
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr = a;
        wd = d;
        wr = w;
        rd = !w;
        @(negedge clk_in);
        wr = 0;
        rd = 0;
    endtask
    task automatic summarize;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            summarize;
        end
    end
    initial begin
        repeat (4) @(negedge clk_in);
        rst_in = 0;
        acc(0, 5'h00, 0); chk(rdata, 16'h2100);
        acc(0, 5'h01, 0); chk(rdata, 16'h0061);
        acc(1, 5'h00, 16'h33FF); acc(1, 5'h01, 16'hFFFF);
        acc(0, 5'h00, 0); chk(rdata, 16'h2100);
        acc(0, 5'h01, 0); chk(rdata, 16'h0061);
        acc(1, 5'h00, 16'hC000);
        acc(0, 5'h00, 0); chk(rdata, 16'hE100);
        repeat (20) @(negedge clk_in);
        acc(0, 5'h00, 0); chk(rdata, 16'h6100);
        link = 1;
        repeat (3) @(negedge clk_in);
        chk({15'h0, lind}, 16'h0000);
        chk({15'h0, mrxdv}, 16'h0001);
        acc(1, 5'h00, 16'h0000);
        repeat (2) @(negedge clk_in);
        chk({15'h0, lind}, 16'h0001);
        link = 0;
        prxdv = 1;
        pin_n = 0;
        acc(0, 5'h00, 0); chk(rdata, 16'h2900);
        chk({15'h0, pwdn}, 16'h0001);
        pin_n = 1;
        acc(1, 5'h00, 16'h0400);
        acc(0, 5'h00, 0); chk(rdata, 16'h2100 | 16'h0400);
        chk({15'h0, mrxdv}, 16'h0000);
        acc(1, 5'h00, 16'h0000);
        acc(0, 5'h00, 0); chk(rdata, 16'h2100);
        chk({15'h0, mrxdv}, 16'h0001);
        @(negedge clk_in) rflt = 1;
        @(negedge clk_in) rflt = 0;
        acc(0, 5'h01, 0); chk(rdata, 16'h0071);
        acc(0, 5'h01, 0); chk(rdata, 16'h0061);
        summarize;
    end
endmodule
`default_nettype wire
